// *** core/irp_filter.sv ***
// Noise canceler: a new input level passes only after it held for hold_cycles clocks.
// Assumes raw is already synchronous to aclk.
`timescale 1ns/1ps
module irp_filter import irp_pkg::*; #(
    parameter int CNT_W = 14
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic raw,
    input wire logic bypass,
    input wire logic [CNT_W-1:0] hold_cycles,
    output logic level
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic level;
    } irp_filter_state_s;

    irp_filter_state_s st_reg;
    irp_filter_state_s st_next;

    always_comb begin
        st_next = st_reg;
        if (bypass) begin
            st_next.level = raw;
            st_next.cnt = '0;
        end else if (raw == st_reg.level) begin
            // A pulse that ends before the count completes is dropped whole.
            st_next.cnt = '0;
        end else if (st_reg.cnt + CNT_W'(1) >= hold_cycles) begin
            st_next.level = raw;
            st_next.cnt = '0;
        end else begin
            st_next.cnt = st_reg.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level = st_reg.level;

endmodule

// *** core/irp_pkg.sv ***
// Types shared by the remote pulse preprocessor modules.
// Assumes a 16-bit AXI4-Lite address and 32-bit data.
package irp_pkg;

    typedef enum logic [1:0] {
        IRP_SRC_RISE = 2'h0,
        IRP_SRC_FALL = 2'h1,
        IRP_SRC_BOTH = 2'h2,
        IRP_SRC_BYTE = 2'h3
    } irp_src_e;

    typedef struct packed {
        logic [1:0] count_clock_select;
        logic input_polarity_select;
        irp_src_e irq_source_select;
        logic [2:0] noise_filter_select;
    } irp_ctrl1_s;

    typedef struct packed {
        logic [3:0] bit_threshold;
        logic counter_run;
        logic preprocessor_enable;
        logic [1:0] measure_mode_select;
    } irp_ctrl2_s;

    typedef struct packed {
        logic [3:0] bit_count_monitor;
        logic reserved;
        logic count_overflow_flag;
        logic threshold_compare_monitor;
        logic filtered_input_monitor;
    } irp_status_s;

    typedef struct packed {
        logic [15:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [15:0] araddr;
        logic arvalid;
        logic rready;
    } irp_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } irp_axi_rsp_s;

endpackage

// *** core/irp_regs.svh ***
// Register map, reset values and timing counts of the remote pulse preprocessor.
// Assumes it is included by bare name by the package users; it holds definitions only.
`ifndef IRP_REGS_SVH
`define IRP_REGS_SVH

// ****************************************************************
// Register indices: the byte address is four times the index.
// ****************************************************************
`define IRP_IDX_CTRL1 14'h0FE8
`define IRP_IDX_CTRL2 14'h0FE9
`define IRP_IDX_CAPT 14'h0FEA
`define IRP_IDX_RXBUF 14'h0FEB
`define IRP_IDX_STAT 14'h0FEC

// ****************************************************************
// Reset values.
// ****************************************************************
`define IRP_CTRL1_RST 8'h00
`define IRP_CTRL2_RST 8'h00
`define IRP_RXBUF_RST 8'h00

// ****************************************************************
// Count clock: divider masks for high_freq_clock/2^6, 2^8, 2^10, 2^12.
// ****************************************************************
`define IRP_DIV_MASK0 12'h03F
`define IRP_DIV_MASK1 12'h0FF
`define IRP_DIV_MASK2 12'h3FF
`define IRP_DIV_MASK3 12'hFFF

// ****************************************************************
// Noise filter: a level must hold 7*2^k high_freq_clock cycles to pass.
// ****************************************************************
`define IRP_NF_CYC1 14'h001C
`define IRP_NF_CYC2 14'h00E0
`define IRP_NF_CYC3 14'h01C0
`define IRP_NF_CYC4 14'h0380
`define IRP_NF_CYC5 14'h0700
`define IRP_NF_CYC6 14'h1C00
`define IRP_NF_CYC7 14'h3800

// ****************************************************************
// Counter and bus constants.
// ****************************************************************
`define IRP_CNT_MAX 8'hFF
`define IRP_BITS_PER_BYTE 4'h8
`define IRP_BITCNT_FIRST 4'h1
`define IRP_RESP_OKAY 2'h0
`define IRP_RESP_SLVERR 2'h2

`endif

// *** core/irp_sync.sv ***
// Three-stage synchroniser for the remote signal pin.
// Assumes the pin is asynchronous to aclk; the output moves only when stages two and three agree.
`timescale 1ns/1ps
module irp_sync import irp_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin,
    output logic level
);

    typedef struct packed {
        logic [2:0] stage;
        logic level;
    } irp_sync_state_s;

    irp_sync_state_s st_reg;
    irp_sync_state_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.stage = {st_reg.stage[1:0], pin};
        if (st_reg.stage[1] == st_reg.stage[2]) begin
            st_next.level = st_reg.stage[2];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level = st_reg.level;

endmodule

// *** core/irp_top.sv ***
// Remote-control pulse preprocessor: noise filter, 8-bit pulse counter and byte decoder.
// Assumes aclk is the high-frequency clock and the pin carries a carrier-free waveform.
`timescale 1ns/1ps
`include "irp_regs.svh"
module irp_top import irp_pkg::*; #(
    parameter logic [13:0] NF_CYC_6 = `IRP_NF_CYC6,
    parameter logic [13:0] NF_CYC_7 = `IRP_NF_CYC7
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire irp_axi_req_s s_axi_req,
    output irp_axi_rsp_s s_axi_rsp,
    input wire logic remote_signal_input,
    output logic remote_irq
);

    // ****************************************************************
    // State.
    // ****************************************************************
    typedef struct packed {
        irp_ctrl1_s ctrl1;
        irp_ctrl2_s ctrl2;
        logic [11:0] div;
        logic [7:0] cnt;
        logic [7:0] capt;
        logic [7:0] rxbuf;
        logic [3:0] bitcnt;
        logic ovf;
        logic lvl_prev;
        logic irq;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
    } irp_core_state_s;

    irp_core_state_s st_reg;
    irp_core_state_s st_next;

    logic pin_sync;
    logic filt_level;
    logic [13:0] hold_cycles;
    logic [11:0] div_mask;
    logic wr_go;
    logic rd_go;
    irp_status_s status;

    // ****************************************************************
    // Input conditioning.
    // ****************************************************************
    // The pin is asynchronous, so nothing but the synchroniser reads it.
    irp_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(remote_signal_input),
        .level(pin_sync)
    );

    // The two longest counts are parameters so that a bench can shorten them.
    always_comb begin
        unique case (st_reg.ctrl1.noise_filter_select)
            3'h1: hold_cycles = `IRP_NF_CYC1;
            3'h2: hold_cycles = `IRP_NF_CYC2;
            3'h3: hold_cycles = `IRP_NF_CYC3;
            3'h4: hold_cycles = `IRP_NF_CYC4;
            3'h5: hold_cycles = `IRP_NF_CYC5;
            3'h6: hold_cycles = NF_CYC_6;
            3'h7: hold_cycles = NF_CYC_7;
            // Code zero bypasses the filter, so this count is never used.
            default: hold_cycles = `IRP_NF_CYC1;
        endcase
    end

    irp_filter #(
        .CNT_W(14)
    ) u_filter (
        .aclk(aclk),
        .aresetn(aresetn),
        .raw(pin_sync),
        .bypass(st_reg.ctrl1.noise_filter_select == 3'h0),
        .hold_cycles(hold_cycles),
        .level(filt_level)
    );

    // ****************************************************************
    // Count clock select.
    // ****************************************************************
    // The divider runs free, so the first tick after a start comes at an arbitrary phase.
    always_comb begin
        unique case (st_reg.ctrl1.count_clock_select)
            2'h0: div_mask = `IRP_DIV_MASK0;
            2'h1: div_mask = `IRP_DIV_MASK1;
            2'h2: div_mask = `IRP_DIV_MASK2;
            2'h3: div_mask = `IRP_DIV_MASK3;
        endcase
    end

    // ****************************************************************
    // Status and bus handshakes.
    // ****************************************************************
    always_comb begin
        status.bit_count_monitor = st_reg.bitcnt;
        // Bit three is unused and reads zero.
        status.reserved = 1'b0;
        status.count_overflow_flag = st_reg.ovf;
        status.threshold_compare_monitor = (st_reg.cnt[7:4] >= st_reg.ctrl2.bit_threshold);
        status.filtered_input_monitor = filt_level;
    end

    // Address and data are taken at one edge, so a write is never left half done.
    // Ready stays low during reset, so nothing is taken before the state is defined.
    assign wr_go = aresetn & s_axi_req.awvalid & s_axi_req.wvalid & ~st_reg.bvalid;
    assign rd_go = aresetn & s_axi_req.arvalid & ~st_reg.rvalid;

    // ****************************************************************
    // Next-state logic.
    // ****************************************************************
    always_comb begin
        logic lvl;
        logic act_edge;
        logic ina_edge;
        logic running;
        logic tick;
        logic meas_evt;
        logic bit_evt;
        logic clr_evt;
        logic ovf_evt;
        logic bit_val;
        logic [3:0] bits_new;
        logic [13:0] wr_idx;
        logic [13:0] rd_idx;
        lvl = 1'b0;
        act_edge = 1'b0;
        ina_edge = 1'b0;
        running = 1'b0;
        tick = 1'b0;
        meas_evt = 1'b0;
        bit_evt = 1'b0;
        clr_evt = 1'b0;
        ovf_evt = 1'b0;
        bit_val = 1'b0;
        bits_new = 4'h0;
        wr_idx = s_axi_req.awaddr[15:2];
        rd_idx = s_axi_req.araddr[15:2];
        st_next = st_reg;
        st_next.irq = 1'b0;
        st_next.div = st_reg.div + 12'h001;

        // ************************************************************
        // Edge detection.
        // ************************************************************
        // Polarity folds into the level, so the active edge is the rising one.
        lvl = filt_level ^ st_reg.ctrl1.input_polarity_select;
        st_next.lvl_prev = lvl;
        running = st_reg.ctrl2.preprocessor_enable & st_reg.ctrl2.counter_run;
        act_edge = running & lvl & ~st_reg.lvl_prev;
        ina_edge = running & ~lvl & st_reg.lvl_prev;
        tick = running & ((st_reg.div & div_mask) == div_mask);

        // ************************************************************
        // Event decode.
        // ************************************************************
        // Mode bit 1 restarts the counter on the other edge, so a width is measured.
        unique case (st_reg.ctrl1.irq_source_select)
            IRP_SRC_RISE: begin
                meas_evt = act_edge;
                clr_evt = ina_edge & st_reg.ctrl2.measure_mode_select[1];
            end
            IRP_SRC_FALL: begin
                meas_evt = ina_edge;
                clr_evt = act_edge & st_reg.ctrl2.measure_mode_select[1];
            end
            IRP_SRC_BOTH: begin
                meas_evt = act_edge | ina_edge;
            end
            IRP_SRC_BYTE: begin
                bit_evt = act_edge;
                clr_evt = ina_edge & st_reg.ctrl2.measure_mode_select[1];
            end
        endcase

        // ************************************************************
        // Counter, overflow and capture.
        // ************************************************************
        // A completing measurement in the same cycle beats the overflow.
        ovf_evt = tick & (st_reg.cnt == `IRP_CNT_MAX) & ~meas_evt & ~bit_evt & ~clr_evt;

        if (tick) begin
            st_next.cnt = st_reg.cnt + 8'h01;
        end
        if (ovf_evt) begin
            st_next.cnt = 8'h00;
            st_next.ovf = 1'b1;
            st_next.irq = 1'b1;
            // Counting stops after an overflow until software sets run again.
            st_next.ctrl2.counter_run = 1'b0;
        end
        if (clr_evt) begin
            st_next.cnt = 8'h00;
        end
        if (meas_evt) begin
            st_next.capt = st_reg.cnt;
            st_next.cnt = 8'h00;
            st_next.irq = 1'b1;
        end

        // ************************************************************
        // Byte decoder.
        // ************************************************************
        if (bit_evt) begin
            bit_val = (st_reg.cnt[7:4] >= st_reg.ctrl2.bit_threshold);
            st_next.capt = st_reg.cnt;
            st_next.cnt = 8'h00;
            st_next.rxbuf = {st_reg.rxbuf[6:0], bit_val};
            // The count holds at eight until the next active edge starts a new byte.
            if (st_reg.bitcnt == `IRP_BITS_PER_BYTE) begin
                bits_new = `IRP_BITCNT_FIRST;
            end else begin
                bits_new = st_reg.bitcnt + 4'h1;
            end
            st_next.bitcnt = bits_new;
            if (bits_new == `IRP_BITS_PER_BYTE) begin
                st_next.irq = 1'b1;
            end
        end

        // ************************************************************
        // Register writes.
        // ************************************************************
        if (st_reg.bvalid && s_axi_req.bready) begin
            st_next.bvalid = 1'b0;
        end
        if (wr_go) begin
            st_next.bvalid = 1'b1;
            st_next.bresp = `IRP_RESP_OKAY;
            unique case (wr_idx)
                `IRP_IDX_CTRL1: begin
                    if (s_axi_req.wstrb[0]) begin
                        st_next.ctrl1 = irp_ctrl1_s'(s_axi_req.wdata[7:0]);
                    end
                end
                `IRP_IDX_CTRL2: begin
                    if (s_axi_req.wstrb[0]) begin
                        st_next.ctrl2 = irp_ctrl2_s'(s_axi_req.wdata[7:0]);
                        // A restart that meets an overflow in the same cycle leaves the flag set.
                        if (s_axi_req.wdata[3]) begin
                            st_next.ovf = ovf_evt;
                        end else begin
                            st_next.cnt = 8'h00;
                            st_next.bitcnt = 4'h0;
                        end
                    end
                end
                // Writes to read-only registers are accepted and dropped.
                `IRP_IDX_CAPT, `IRP_IDX_RXBUF, `IRP_IDX_STAT: begin
                    st_next.bresp = `IRP_RESP_OKAY;
                end
                default: begin
                    st_next.bresp = `IRP_RESP_SLVERR;
                end
            endcase
        end

        // ************************************************************
        // Register reads.
        // ************************************************************
        if (st_reg.rvalid && s_axi_req.rready) begin
            st_next.rvalid = 1'b0;
        end
        if (rd_go) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = `IRP_RESP_OKAY;
            unique case (rd_idx)
                `IRP_IDX_CTRL1: st_next.rdata = st_reg.ctrl1;
                `IRP_IDX_CTRL2: st_next.rdata = st_reg.ctrl2;
                `IRP_IDX_CAPT: st_next.rdata = st_reg.capt;
                `IRP_IDX_RXBUF: st_next.rdata = st_reg.rxbuf;
                `IRP_IDX_STAT: st_next.rdata = status;
                // An unmapped read answers zero and an error, so a hole is visible.
                default: begin
                    st_next.rdata = 8'h00;
                    st_next.rresp = `IRP_RESP_SLVERR;
                end
            endcase
        end
    end

    // ****************************************************************
    // State register.
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
            st_reg.ctrl1 <= `IRP_CTRL1_RST;
            st_reg.ctrl2 <= `IRP_CTRL2_RST;
            st_reg.rxbuf <= `IRP_RXBUF_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    always_comb begin
        s_axi_rsp.awready = wr_go;
        s_axi_rsp.wready = wr_go;
        s_axi_rsp.bresp = st_reg.bresp;
        s_axi_rsp.bvalid = st_reg.bvalid;
        s_axi_rsp.arready = aresetn & ~st_reg.rvalid;
        // Only the low byte holds a register; the upper bits read zero.
        s_axi_rsp.rdata = {24'h000000, st_reg.rdata};
        s_axi_rsp.rresp = st_reg.rresp;
        s_axi_rsp.rvalid = st_reg.rvalid;
    end

    assign remote_irq = st_reg.irq;

endmodule

// *** verif/irp_ir_model.sv ***
// Model of the external receiver that hands over the carrier-free remote waveform.
// Assumes its task is called just after a rising edge of aclk.
`timescale 1ns/1ps
module irp_ir_model (
    input wire logic aclk,
    output logic rx
);
    // The receiver rests at space level, so the pin is low between frames.
    initial rx = 1'b0;
    task automatic hold(input logic lvl, input int n);
        rx <= lvl;
        repeat (n) @(posedge aclk);
    endtask
endmodule

// *** verif/irp_top_assertions.sv ***
// Checker for the remote pulse preprocessor ports: register bus handshakes and interrupt shape.
// Assumes it is bound into irp_top and sees only the ports of that module.
`timescale 1ns/1ps
module irp_top_checker import irp_pkg::*; #(
    parameter logic [13:0] NF_CYC_6 = 14'h1C00,
    parameter logic [13:0] NF_CYC_7 = 14'h3800
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire irp_axi_req_s s_axi_req,
    input wire irp_axi_rsp_s s_axi_rsp,
    input wire logic remote_signal_input,
    input wire logic remote_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ****************************************************************
    // Properties.
    // ****************************************************************
    property p_irq_pulse; remote_irq |=> !remote_irq [*2]; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt request wider than one cycle");
    property p_aw_pair; s_axi_rsp.awready |-> s_axi_rsp.wready && s_axi_req.wvalid && !s_axi_rsp.bvalid; endproperty
    a_aw_pair: assert property (p_aw_pair) else $error("write address taken without its data");
    property p_b_answer; s_axi_req.awvalid && s_axi_rsp.awready |=> s_axi_rsp.bvalid; endproperty
    a_b_answer: assert property (p_b_answer) else $error("write response late");
    property p_b_hold; s_axi_rsp.bvalid && !s_axi_req.bready |=> s_axi_rsp.bvalid && $stable(s_axi_rsp.bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_b_release; s_axi_rsp.bvalid && s_axi_req.bready |=> !s_axi_rsp.bvalid; endproperty
    a_b_release: assert property (p_b_release) else $error("write response repeated");
    property p_r_answer; s_axi_req.arvalid && s_axi_rsp.arready |=> s_axi_rsp.rvalid && !s_axi_rsp.arready; endproperty
    a_r_answer: assert property (p_r_answer) else $error("read response late");
    property p_r_hold;
        s_axi_rsp.rvalid && !s_axi_req.rready |=> s_axi_rsp.rvalid && $stable(s_axi_rsp.rdata) && $stable(s_axi_rsp.rresp);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data changed while waiting");
    property p_r_word; s_axi_rsp.rvalid |-> s_axi_rsp.rdata[31:8] == 24'h0 && (s_axi_rsp.rresp == 2'h0 ||
        s_axi_rsp.rdata == 32'h0); endproperty
    a_r_word: assert property (p_r_word) else $error("read data outside the register byte");
    c_irq: cover property (remote_irq);
    c_slverr: cover property (s_axi_rsp.bvalid && s_axi_rsp.bresp == 2'h2);
    c_read: cover property (s_axi_rsp.rvalid && s_axi_req.rready);
endmodule

bind irp_top irp_top_checker #(.NF_CYC_6(NF_CYC_6), .NF_CYC_7(NF_CYC_7)) u_irp_top_checker (.aclk(aclk),
    .aresetn(aresetn), .s_axi_req(s_axi_req), .s_axi_rsp(s_axi_rsp), .remote_signal_input(remote_signal_input),
    .remote_irq(remote_irq));

// *** verif/tb.sv ***
// Self-checking bench for the remote pulse preprocessor, driven over its register bus and pin.
// Assumes the design files and the receiver model are compiled before it.
`timescale 1ns/1ps
`include "irp_regs.svh"
module tb import irp_pkg::*;;
    localparam logic [13:0] I1 = `IRP_IDX_CTRL1;
    localparam logic [13:0] I2 = `IRP_IDX_CTRL2;
    localparam logic [13:0] IC = `IRP_IDX_CAPT;
    localparam logic [13:0] IB = `IRP_IDX_RXBUF;
    localparam logic [13:0] IS = `IRP_IDX_STAT;
    localparam logic [1:0] OK = `IRP_RESP_OKAY;
    localparam logic [1:0] ERR = `IRP_RESP_SLVERR;
    localparam logic [7:0] T_C1 [8] = '{8'h00, 8'h00, 8'h08, 8'h20, 8'h10, 8'h40, 8'h80, 8'hC0};
    localparam logic [7:0] T_MD [8] = '{8'h00, 8'h02, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam int T_IRQ [8] = '{2, 2, 2, 2, 4, 2, 2, 2};
    localparam int T_LO [8] = '{31, 23, 31, 7, 7, 7, 1, 0};
    localparam int T_HI [8] = '{33, 25, 33, 9, 9, 9, 3, 1};
    localparam logic [2:0] F_CODE [3] = '{3'h1, 3'h6, 3'h7};
    localparam int F_SHORT [3] = '{27, 39, 59};
    localparam int F_LONG [3] = '{37, 45, 65};
    localparam logic [6:0] BPAT = 7'h59;
    logic aclk;
    logic aresetn;
    irp_axi_req_s req;
    irp_axi_rsp_s rsp;
    logic rx_pin;
    logic irq;
    logic [7:0] d;
    logic [1:0] r;
    int errors;
    int tests_run;
    int irqs;
    int n;

    // Filter counts shortened so the two longest settings finish quickly.
    irp_top #(.NF_CYC_6(14'h0028), .NF_CYC_7(14'h003C)) u_irp_top (.aclk(aclk), .aresetn(aresetn), .s_axi_req(req),
        .s_axi_rsp(rsp), .remote_signal_input(rx_pin), .remote_irq(irq));
    irp_ir_model u_ir (.aclk(aclk), .rx(rx_pin));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    always @(posedge aclk) if (irq === 1'b1) irqs++;

    // ****************************************************************
    // Bus tasks and checks.
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic inr(input logic [31:0] v, input int lo, input int hi);
        chk({31'h0, !$isunknown(v) && v >= lo && v <= hi}, 32'h1);
    endtask

    task automatic wr(input logic [13:0] idx, input logic [7:0] v, input logic [1:0] er);
        logic ok;
        @(posedge aclk);
        req.awaddr <= {idx, 2'h0};
        req.wdata <= {24'h0, v};
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            #1;
            ok = rsp.awready;
            @(posedge aclk);
        end while (ok !== 1'b1);
        req.awvalid <= 1'b0;
        req.wvalid <= 1'b0;
        do begin
            #1;
            ok = rsp.bvalid;
            r = rsp.bresp;
            @(posedge aclk);
        end while (ok !== 1'b1);
        req.bready <= 1'b0;
        chk({30'h0, r}, {30'h0, er});
    endtask

    task automatic rd(input logic [13:0] idx, input logic [1:0] er);
        logic ok;
        @(posedge aclk);
        req.araddr <= {idx, 2'h0};
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            #1;
            ok = rsp.arready;
            @(posedge aclk);
        end while (ok !== 1'b1);
        req.arvalid <= 1'b0;
        do begin
            #1;
            ok = rsp.rvalid;
            d = rsp.rdata[7:0];
            r = rsp.rresp;
            @(posedge aclk);
        end while (ok !== 1'b1);
        req.rready <= 1'b0;
        chk({30'h0, r}, {30'h0, er});
    endtask

    task automatic conclude();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge aclk);
        errors++;
        $display("BAD %0t watchdog expired", $time);
        conclude();
    end

    // ****************************************************************
    // Test sequence.
    // ****************************************************************
    initial begin
        req = '0;
        aresetn = 1'b0;
        errors = 0;
        tests_run = 0;
        irqs = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(I1 + 14'(i), OK);
            chk({24'h0, d}, 32'h0);
        end
        rd(IS, OK);
        chk({24'h0, d}, 32'h02);
        rd(14'h0FED, ERR);
        chk({24'h0, d}, 32'h0);
        wr(14'h0FED, 8'hFF, ERR);
        wr(IC, 8'h5A, OK);
        rd(IC, OK);
        chk({24'h0, d}, 32'h0);
        wr(I1, 8'hA5, OK);
        rd(I1, OK);
        chk({24'h0, d}, 32'hA5);
        for (int i = 0; i < 8; i++) begin
            wr(I2, 8'h04, OK);
            wr(I1, T_C1[i], OK);
            irqs = 0;
            wr(I2, 8'h0C | T_MD[i], OK);
            repeat (2) begin
                u_ir.hold(1'b1, 512);
                u_ir.hold(1'b0, 1536);
            end
            chk(irqs, T_IRQ[i]);
            rd(IC, OK);
            inr({24'h0, d}, T_LO[i], T_HI[i]);
        end
        wr(I2, 8'h04, OK);
        wr(I1, 8'h00, OK);
        irqs = 0;
        n = 0;
        wr(I2, 8'h0C, OK);
        while (irqs == 0 && n < 20000) begin
            @(posedge aclk);
            n++;
        end
        inr(n, 16300, 16400);
        repeat (300) @(posedge aclk);
        chk(irqs, 1);
        rd(IS, OK);
        chk({24'h0, d}, 32'h06);
        rd(I2, OK);
        chk({24'h0, d}, 32'h04);
        wr(I2, 8'h0C, OK);
        rd(IS, OK);
        chk({24'h0, d}, 32'h02);
        for (int i = 0; i < 3; i++) begin
            wr(I2, 8'h04, OK);
            wr(I1, {5'h0, F_CODE[i]}, OK);
            wr(I2, 8'h0C, OK);
            irqs = 0;
            u_ir.hold(1'b1, F_SHORT[i]);
            u_ir.hold(1'b0, 200);
            chk(irqs, 0);
            u_ir.hold(1'b1, F_LONG[i]);
            rd(IS, OK);
            chk({31'h0, d[0]}, 32'h1);
            u_ir.hold(1'b0, 200);
            chk(irqs, 1);
        end
        wr(I2, 8'h04, OK);
        wr(I1, 8'h18, OK);
        irqs = 0;
        wr(I2, 8'h2C, OK);
        u_ir.hold(1'b0, 200);
        // A long period decides a one and a short period a zero against threshold two.
        for (int i = 0; i < 7; i++) begin
            u_ir.hold(1'b1, 512);
            u_ir.hold(1'b0, BPAT[6-i] ? 2560 : 512);
        end
        u_ir.hold(1'b1, 512);
        u_ir.hold(1'b0, 300);
        chk(irqs, 1);
        rd(IB, OK);
        chk({24'h0, d}, 32'h59);
        rd(IC, OK);
        inr({24'h0, d}, 47, 49);
        rd(IS, OK);
        chk({24'h0, d}, 32'h80);
        u_ir.hold(1'b1, 512);
        u_ir.hold(1'b0, 100);
        rd(IS, OK);
        chk({24'h0, d}, 32'h10);
        conclude();
    end
endmodule
